// ### rtl/lsrd_defines.svh
// constants for the line status and ring detect block
// Operation
// - off-hook loop current five bits, 3.3 mA/step
// - codes low, normal, 11111 excessive current
// - maximum code sets overload flag
// - on-hook line voltage seven bits, 1 V/step
// - hook control bit seizes the line
// - off-hook reaches line side within 250 us
// - off-hook counter delays data path
// - then 256 ms ADC calibration
// - calibration disable bit skips calibration
// - filter delay 1.5 ms before usable data
// - ring status bits at 6, 5, 2
// - full-wave select defaults zero, positive only
// - ring polarity bits follow thresholds
// - ring detected set per full-wave select
// - half-wave codec codes -32768 / +32767
// - full-wave codec codes +1228 / +32767 / -32768
// - ring detected retriggerable 5 s one-shot
// - off-hook clears ring detected at once
// - loop current code in register 12 bits 4:0
`ifndef LSRD_DEFINES_SVH
`define LSRD_DEFINES_SVH
// register offsets are indexes; byte address is four times index
`define LSRD_IDX_HOOK        5
`define LSRD_IDX_INTR        4
`define LSRD_IDX_POWER       6
`define LSRD_IDX_LOOP        12
`define LSRD_IDX_CAL         17
`define LSRD_IDX_RINGCFG     18
`define LSRD_IDX_VOLT        29
// field positions
`define LSRD_HOOK_BIT        0
`define LSRD_RING_DET_BIT    2
`define LSRD_RING_POS_BIT    5
`define LSRD_RING_NEG_BIT    6
`define LSRD_CALDIS_BIT      5
`define LSRD_FWR_BIT         1
`define LSRD_OVL_BIT         2
`define LSRD_DROP_BIT        3
`define LSRD_FRAME_BIT       6
`define LSRD_POWERDOWN_BIT   4
// codes
`define LSRD_LOOP_MAX        5'h1F
`define LSRD_CODEC_MIN       16'h8000
`define LSRD_CODEC_MAX       16'h7FFF
`define LSRD_CODEC_FW_IDLE   16'h04CC
// times and rate
`define LSRD_CLK_MHZ         200
`define LSRD_LAT_US          250
`define LSRD_DLY_US          1500
`define LSRD_CAL_MS          256
`define LSRD_RING_MS         5000
`define LSRD_LAT_CYC         (`LSRD_LAT_US * `LSRD_CLK_MHZ)
`define LSRD_CAL_CYC         (`LSRD_CAL_MS * 1000 * `LSRD_CLK_MHZ)
`define LSRD_DLY_CYC         (`LSRD_DLY_US * `LSRD_CLK_MHZ)
`define LSRD_PRE_CYC         (1000 * `LSRD_CLK_MHZ)
`endif

// ### rtl/lsrd_pkg.sv
// types of the line status and ring detect block
package lsrd_pkg;
  typedef enum logic [2:0] {
    LSRD_ONHOOK  = 3'b000,
    LSRD_LATENCY = 3'b001,
    LSRD_SETTLE  = 3'b010,
    LSRD_CALIB   = 3'b011,
    LSRD_READY   = 3'b100
  } lsrd_hook_t;
endpackage

// ### rtl/lsrd_line_status.sv
// line status, off-hook sequencing and ring detect with axi4-lite slave
`timescale 1ns/1ps
`include "lsrd_defines.svh"
module lsrd_line_status
  import lsrd_pkg::*;
#(
  parameter int LAT_CYC = `LSRD_LAT_CYC,   // line-side latency in cycles
  parameter int DLY_CYC = `LSRD_DLY_CYC,   // off-hook counter plus filter delay
  parameter int CAL_CYC = `LSRD_CAL_CYC,   // calibration length
  parameter int PRE_CYC = `LSRD_PRE_CYC,   // one millisecond prescaler
  parameter int RING_MS = `LSRD_RING_MS    // one-shot length in ms
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [4:0]  loop_current_sample,  // line-side current measurement
  input  wire logic [6:0]  line_voltage_sample,  // line-side voltage measurement
  input  wire logic        ring_above_pos,       // signal above positive threshold
  input  wire logic        ring_below_neg,       // signal below negative threshold
  input  wire logic        dropout_event,        // loop collapse pulse from line side
  input  wire logic        frame_detect_status,  // link framed
  output logic             line_seize,           // termination applied on line side
  output logic             data_path_ready,      // tx/rx usable
  output logic             calibrating,          // adc calibration running
  output logic [15:0]      codec_data,           // on-hook codec sample
  output logic             line_side_powerdown   // powerdown to line side
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic        hook_control;           // software off-hook request
  logic        calibration_disable;    // skip calibration
  logic        full_wave_ring_select;  // report both polarities
  logic        loop_current_overload_flag;
  logic        dropout_detect_flag;
  logic [4:0]  loop_current_code;
  logic [6:0]  line_voltage_code;
  logic        ring_detected_status;
  logic        next_hook_control, next_calibration_disable, next_full_wave_ring_select;
  logic        next_overload, next_dropout, next_powerdown;
  logic [4:0]  next_loop;
  logic [6:0]  next_volt;

  // bus handshake state
  logic        aw_held, w_held;        // address/data accepted, waiting pair
  logic [31:0] aw_addr, w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [31:0] next_aw_addr, next_w_data, next_rdata;
  logic [3:0]  next_w_strb;
  logic [1:0]  next_bresp, next_rresp;

  // sequencer and ring state
  lsrd_hook_t  hook_state, next_hook_state;
  logic [31:0] seq_cnt, next_seq_cnt;
  logic [31:0] pre_cnt, next_pre_cnt;    // millisecond prescaler
  logic [15:0] ring_ms, next_ring_ms;    // one-shot remaining ms
  logic        next_ring_detected;
  logic [15:0] next_codec;
  logic        offhook_line;             // line side is off-hook

  ////////////////////////////////////////////////////////////////////////////
  // write decode helpers
  logic        wr_fire;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx  = aw_addr[9:2];
  assign rd_idx  = s_axi_araddr[9:2];
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;  // one read at a time
  assign offhook_line  = (hook_state != LSRD_ONHOOK) && (hook_state != LSRD_LATENCY);
  assign line_seize    = offhook_line;
  assign data_path_ready = (hook_state == LSRD_READY);
  assign calibrating   = (hook_state == LSRD_CALIB);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave next state; writes are taken when both halves present
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin  // capture address
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin    // capture data
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin                          // commit and respond
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_idx == 8'(`LSRD_IDX_HOOK) || wr_idx == 8'(`LSRD_IDX_INTR) ||
                      wr_idx == 8'(`LSRD_IDX_CAL) || wr_idx == 8'(`LSRD_IDX_RINGCFG) ||
                      wr_idx == 8'(`LSRD_IDX_POWER)) ? 2'h0 : 2'h2;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin   // read answer one cycle later
      next_rvalid = 1'b1;
      next_rresp  = 2'h0;
      next_rdata  = 32'h0;
      unique case (rd_idx)
        8'(`LSRD_IDX_HOOK): begin
          next_rdata[`LSRD_HOOK_BIT] = hook_control;
          next_rdata[`LSRD_RING_DET_BIT] = ring_detected_status;
          next_rdata[`LSRD_RING_POS_BIT] = ring_above_pos;
          next_rdata[`LSRD_RING_NEG_BIT] = ring_below_neg;
        end
        8'(`LSRD_IDX_INTR): begin
          next_rdata[`LSRD_OVL_BIT]  = loop_current_overload_flag;
          next_rdata[`LSRD_DROP_BIT] = dropout_detect_flag;
        end
        8'(`LSRD_IDX_POWER): next_rdata[`LSRD_POWERDOWN_BIT] = line_side_powerdown;
        8'(`LSRD_IDX_LOOP): begin
          next_rdata[4:0]            = loop_current_code;
          next_rdata[`LSRD_FRAME_BIT] = frame_detect_status;
        end
        8'(`LSRD_IDX_CAL):     next_rdata[`LSRD_CALDIS_BIT] = calibration_disable;
        8'(`LSRD_IDX_RINGCFG): next_rdata[`LSRD_FWR_BIT]    = full_wave_ring_select;
        8'(`LSRD_IDX_VOLT):    next_rdata[6:0] = line_voltage_code;
        default:           next_rresp = 2'h2;           // unmapped
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // bus slave registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0; aw_addr <= 32'h0; w_held <= 1'b0; w_data <= 32'h0;
      w_strb <= 4'h0; s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0; s_axi_rresp <= 2'h0;
    end else begin
      aw_held <= next_aw_held; aw_addr <= next_aw_addr;
      w_held <= next_w_held; w_data <= next_w_data; w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid; s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid; s_axi_rdata <= next_rdata; s_axi_rresp <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and status registers
  always_comb begin
    next_hook_control          = hook_control;
    next_calibration_disable   = calibration_disable;
    next_full_wave_ring_select = full_wave_ring_select;
    next_powerdown             = line_side_powerdown;
    next_overload              = loop_current_overload_flag;
    next_dropout               = dropout_detect_flag;
    next_loop                  = loop_current_code;
    next_volt                  = line_voltage_code;
    if (wr_fire && w_strb[0]) begin
      unique case (wr_idx)
        8'(`LSRD_IDX_HOOK):    next_hook_control = w_data[`LSRD_HOOK_BIT];
        8'(`LSRD_IDX_CAL):     next_calibration_disable = w_data[`LSRD_CALDIS_BIT];
        8'(`LSRD_IDX_RINGCFG): next_full_wave_ring_select = w_data[`LSRD_FWR_BIT];
        8'(`LSRD_IDX_POWER):   next_powerdown = w_data[`LSRD_POWERDOWN_BIT];
        8'(`LSRD_IDX_INTR): begin          // write zero clears a flag
          if (!w_data[`LSRD_OVL_BIT])  next_overload = 1'b0;
          if (!w_data[`LSRD_DROP_BIT]) next_dropout  = 1'b0;
        end
        default: ;
      endcase
    end
    // measurements track only in their hook state, else hold
    if (offhook_line) next_loop = loop_current_sample;
    else              next_volt = line_voltage_sample;
    // set wins over a clear in the same cycle
    if (offhook_line && loop_current_sample == `LSRD_LOOP_MAX)
      next_overload = 1'b1;
    if (dropout_event) next_dropout = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hook_control <= 1'b0; calibration_disable <= 1'b0;
      full_wave_ring_select <= 1'b0;
      line_side_powerdown <= 1'b1;
      loop_current_overload_flag <= 1'b0; dropout_detect_flag <= 1'b0;
      loop_current_code <= 5'h00; line_voltage_code <= 7'h00;
    end else begin
      hook_control <= next_hook_control; calibration_disable <= next_calibration_disable;
      full_wave_ring_select <= next_full_wave_ring_select;
      line_side_powerdown <= next_powerdown;
      loop_current_overload_flag <= next_overload; dropout_detect_flag <= next_dropout;
      loop_current_code <= next_loop; line_voltage_code <= next_volt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // off-hook sequencer: latency, settle delay, calibration, ready
  always_comb begin
    next_hook_state = hook_state;
    next_seq_cnt    = seq_cnt + 32'd1;
    unique case (hook_state)
      LSRD_ONHOOK: begin
        next_seq_cnt = 32'd0;
        if (hook_control) next_hook_state = LSRD_LATENCY;
      end
      LSRD_LATENCY: begin
        if (seq_cnt >= 32'(LAT_CYC - 1)) begin
          next_hook_state = LSRD_SETTLE;
          next_seq_cnt    = 32'd0;
        end
      end
      LSRD_SETTLE: begin
        if (seq_cnt >= 32'(DLY_CYC - 1)) begin
          next_hook_state = calibration_disable ? LSRD_READY : LSRD_CALIB;
          next_seq_cnt    = 32'd0;
        end
      end
      LSRD_CALIB: begin
        if (seq_cnt >= 32'(CAL_CYC - 1)) begin
          next_hook_state = LSRD_READY;
          next_seq_cnt    = 32'd0;
        end
      end
      LSRD_READY: next_seq_cnt = 32'd0;
    endcase
    // dropping the hook bit always returns on-hook at once
    if (!hook_control) next_hook_state = LSRD_ONHOOK;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hook_state <= LSRD_ONHOOK;
      seq_cnt    <= 32'd0;
    end else begin
      hook_state <= next_hook_state;
      seq_cnt    <= next_seq_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ring detect one-shot and codec codes
  logic ring_hit;
  assign ring_hit = ring_above_pos || (full_wave_ring_select && ring_below_neg);

  always_comb begin
    next_pre_cnt       = (pre_cnt >= 32'(PRE_CYC - 1)) ? 32'd0 : pre_cnt + 32'd1;
    next_ring_ms       = ring_ms;
    next_ring_detected = ring_detected_status;
    if (ring_hit) begin                                       // retrigger
      next_ring_ms       = 16'(RING_MS);
      next_pre_cnt       = 32'd0;
      next_ring_detected = 1'b1;
    end else if (ring_detected_status && pre_cnt >= 32'(PRE_CYC - 1)) begin
      next_ring_ms = ring_ms - 16'd1;
      if (ring_ms <= 16'd1) next_ring_detected = 1'b0;        // expiry
    end
    if (hook_control) begin
      next_ring_detected = 1'b0;
      next_ring_ms       = 16'd0;
    end
    // codec codes; limited to on-hook, else last code held
    if (!full_wave_ring_select)
      next_codec = ring_above_pos ? `LSRD_CODEC_MAX : `LSRD_CODEC_MIN;
    else if (ring_above_pos)
      next_codec = `LSRD_CODEC_MAX;
    else if (ring_below_neg)
      next_codec = `LSRD_CODEC_MIN;
    else
      next_codec = `LSRD_CODEC_FW_IDLE;
    if (offhook_line) next_codec = codec_data;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt <= 32'd0; ring_ms <= 16'd0;
      ring_detected_status <= 1'b0; codec_data <= `LSRD_CODEC_MIN;
    end else begin
      pre_cnt <= next_pre_cnt; ring_ms <= next_ring_ms;
      ring_detected_status <= next_ring_detected; codec_data <= next_codec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // overload flag and ring detected bit
  overload_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    offhook_line && loop_current_sample == `LSRD_LOOP_MAX |=> loop_current_overload_flag)
    else $error("overload flag missed");
  ring_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hook_control |=> !ring_detected_status) else $error("ring bit not cleared");
  ring_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ring_above_pos && !hook_control |=> ring_detected_status)
    else $error("ring bit not set");
  neg_half_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !full_wave_ring_select && ring_below_neg && !ring_above_pos && !ring_detected_status
    && !hook_control |=> !ring_detected_status) else $error("neg ring in half wave");
  ring_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
    full_wave_ring_select && ring_below_neg && !hook_control |=> ring_detected_status)
    else $error("neg ring missed in full wave");

  // one-shot: holds while time is left, drops on the last tick
  ring_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ring_detected_status && !hook_control && ring_ms > 16'h0001 |=> ring_detected_status)
    else $error("ring bit dropped early");
  ring_expire_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ring_detected_status && !ring_hit && !hook_control && ring_ms == 16'h0001
    && pre_cnt >= 32'(PRE_CYC - 1) |=> !ring_detected_status) else $error("ring bit stuck");

  // codec sample codes while on-hook
  codec_half_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !offhook_line && !full_wave_ring_select && !ring_above_pos
    |=> codec_data == `LSRD_CODEC_MIN) else $error("half wave idle code");
  codec_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !offhook_line && full_wave_ring_select && !ring_above_pos && !ring_below_neg
    |=> codec_data == `LSRD_CODEC_FW_IDLE) else $error("full wave idle code");
  codec_pos_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !offhook_line && ring_above_pos |=> codec_data == `LSRD_CODEC_MAX)
    else $error("positive ring code");
  codec_neg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !offhook_line && full_wave_ring_select && ring_below_neg && !ring_above_pos
    |=> codec_data == `LSRD_CODEC_MIN) else $error("negative ring code");

  // off-hook sequencer phases and their bounds
  seize_late_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(hook_control) |=> !line_seize) else $error("seized before latency");
  latency_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hook_state == LSRD_LATENCY |-> seq_cnt < 32'(LAT_CYC))
    else $error("latency overrun");
  onhook_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !hook_control |=> hook_state == LSRD_ONHOOK)
    else $error("hook release ignored");
  calib_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hook_state == LSRD_SETTLE && hook_control && !calibration_disable
    && seq_cnt == 32'(DLY_CYC - 1) |=> calibrating) else $error("calibration not started");
  calib_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    calibrating |-> seq_cnt < 32'(CAL_CYC))
    else $error("calibration overrun");
  skip_cal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hook_state == LSRD_SETTLE && calibration_disable |=> !calibrating)
    else $error("calibration not skipped");

  // measurement codes follow the hook state
  volt_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    offhook_line && $past(offhook_line) |-> $stable(line_voltage_code))
    else $error("voltage moved off-hook");
  loop_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
    offhook_line |=> loop_current_code == $past(loop_current_sample))
    else $error("loop code not tracking");

endmodule

// ### test/lsrd_line_model.sv
// behavioural model of the telephone line seen by the block
`timescale 1ns/1ps
module lsrd_line_model (
  input  wire logic       aclk,
  input  wire logic       line_seize,
  input  wire logic       line_side_powerdown,
  input  wire logic [4:0] loop_set,   // current the loop can give
  input  wire logic [6:0] volt_set,   // idle line voltage code
  input  wire logic [1:0] ring_cmd,   // bit0 positive, bit1 negative swing
  input  wire logic       drop_req,   // loop collapse pulse
  output logic [4:0]      loop_current_sample,
  output logic [6:0]      line_voltage_sample,
  output logic            ring_above_pos,
  output logic            ring_below_neg,
  output logic            dropout_event,
  output logic            frame_detect_status
);
  logic [2:0] frame_cnt;  // link training delay
  ////////////////////////////////////////
  // framing appears a few cycles after power-up, lost at powerdown
  always_ff @(posedge aclk) begin
    if (line_side_powerdown) frame_cnt <= 3'h0;
    else if (frame_cnt != 3'h7) frame_cnt <= frame_cnt + 3'h1;
  end
  assign frame_detect_status = (frame_cnt == 3'h7);
  // no dc current until termination is applied
  assign loop_current_sample = line_seize ? loop_set : 5'h00;
  // a loaded line sags far below its idle level
  assign line_voltage_sample = line_seize ? (volt_set >> 2) : volt_set;
  assign ring_above_pos = ring_cmd[0];
  assign ring_below_neg = ring_cmd[1];
  assign dropout_event = drop_req;
endmodule

// ### test/test_line_status_ring_detect.sv
// self-checking bench of the line status and ring detect block
`timescale 1ns/1ps
module test_line_status_ring_detect;
  localparam int LAT = 4;
  localparam int DLY = 4;
  localparam int CAL = 8;
  logic        aclk, aresetn, drop_req;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ring_cmd;
  logic [4:0]  loop_current_sample, loop_set, lp;
  logic [6:0]  line_voltage_sample, volt_set, vt;
  logic        ring_above_pos, ring_below_neg, dropout_event, frame_detect_status;
  logic        line_seize, data_path_ready, calibrating, line_side_powerdown;
  logic [15:0] codec_data;
  logic [33:0] notes[$];  // expected read data and response
  logic [1:0]  bnotes[$]; // expected write responses
  logic [33:0] note;
  int          num_errors, tests_run;
  lsrd_line_status #(.LAT_CYC(LAT), .DLY_CYC(DLY), .CAL_CYC(CAL), .PRE_CYC(4), .RING_MS(3))
  i_lsrd_line_status (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .loop_current_sample, .line_voltage_sample,
    .ring_above_pos, .ring_below_neg, .dropout_event, .frame_detect_status, .line_seize,
    .data_path_ready, .calibrating, .codec_data, .line_side_powerdown);
  lsrd_line_model i_lsrd_line_model (.aclk, .line_seize, .line_side_powerdown, .loop_set,
    .volt_set, .ring_cmd, .drop_req, .loop_current_sample, .line_voltage_sample,
    .ring_above_pos, .ring_below_neg, .dropout_event, .frame_detect_status);
  ////////////////////////////////////////
  task automatic print_verdict;
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input int idx, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    bnotes.push_back(er);
    s_axi_awaddr <= 32'(idx * 4);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  // read: expectation noted first, the monitor compares on the answer
  task automatic rd(input int idx, input logic [31:0] d, input logic [1:0] er);
    notes.push_back({d, er});
    s_axi_araddr <= 32'(idx * 4);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    // rready stays high, so back-to-back reads never toggle it in one step
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
  endtask
  // off-hook, then count phases at falling edges where outputs are settled
  task automatic hook_on(input int cal);
    int lat_n, seize_n, cal_n;
    lat_n = 0;
    seize_n = 0;
    cal_n = 0;
    wr(5, 32'h1, 2'h0);
    repeat (40) begin
      @(negedge aclk);
      if (line_seize !== 1'b1 && seize_n == 0) lat_n++;
      if (line_seize === 1'b1 && data_path_ready !== 1'b1) seize_n++;
      if (calibrating === 1'b1) cal_n++;
    end
    chk("latency", 32'h1, 32'(lat_n > 0 && lat_n <= LAT));
    chk("settle", 32'(DLY + cal), 32'(seize_n));
    chk("calib", 32'(cal), 32'(cal_n));
    chk("ready", 32'h1, 32'(data_path_ready));
    @(posedge aclk);
  endtask
  task automatic codec(input logic [15:0] ex);
    repeat (3) @(posedge aclk);
    chk("codec", 32'(ex), 32'(codec_data));
  endtask
  ////////////////////////////////////////
  // read monitor takes the oldest note per answer
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      chk("rdata", note[33:2], s_axi_rdata);
      chk("rresp", 32'(note[1:0]), 32'(s_axi_rresp));
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && bnotes.size() > 0)
      chk("bresp", 32'(bnotes.pop_front()), 32'(s_axi_bresp));
  end
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // watchdog far beyond the few hundred cycles of the run
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    print_verdict;
  end
  initial begin
    {aresetn, drop_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, ring_cmd, loop_set, volt_set} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'hD770));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(6, 32'h10, 2'h0);
    rd(18, 32'h0, 2'h0);
    rd(1, 32'h0, 2'h2);
    wr(1, 32'hFF, 2'h2);
    wr(6, 32'h0, 2'h0);
    repeat (12) @(posedge aclk);
    rd(12, 32'h40, 2'h0);
    lp = 5'(4 + $urandom % 27);
    vt = 7'(4 + $urandom % 123);
    volt_set <= vt;
    repeat (3) @(posedge aclk);
    rd(29, 32'(vt), 2'h0);
    ring_cmd <= 2'b10;
    codec(16'h8000);
    rd(5, 32'h40, 2'h0);
    ring_cmd <= 2'b01;
    codec(16'h7FFF);
    rd(5, 32'h24, 2'h0);
    ring_cmd <= 2'b00;
    codec(16'h8000);
    rd(5, 32'h04, 2'h0);
    repeat (20) @(posedge aclk);
    rd(5, 32'h0, 2'h0);
    wr(18, 32'h2, 2'h0);
    codec(16'h04CC);
    ring_cmd <= 2'b10;
    codec(16'h8000);
    rd(5, 32'h44, 2'h0);
    ring_cmd <= 2'b01;
    codec(16'h7FFF);
    loop_set <= lp;
    hook_on(CAL);
    rd(5, 32'h21, 2'h0);
    rd(12, 32'(lp) | 32'h40, 2'h0);
    rd(29, 32'(vt), 2'h0);
    loop_set <= 5'h1F;
    repeat (3) @(posedge aclk);
    rd(12, 32'h5F, 2'h0);
    rd(4, 32'h04, 2'h0);
    loop_set <= 5'h03;
    drop_req <= 1'b1;
    @(posedge aclk);
    drop_req <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(4, 32'h0C, 2'h0);
    wr(4, 32'h0, 2'h0);
    rd(4, 32'h0, 2'h0);
    rd(12, 32'h43, 2'h0);
    ring_cmd <= 2'b00;
    wr(5, 32'h0, 2'h0);
    repeat (3) @(posedge aclk);
    rd(12, 32'h43, 2'h0);
    wr(17, 32'h20, 2'h0);
    hook_on(0);
    print_verdict;
  end
endmodule
